// ==== rtl/lcw_defs.vh ====
// constants for the write-only two-wire display front end
// assumes a single 100 MHz clock and synchronous pin inputs
`ifndef LCW_DEFS_VH
`define LCW_DEFS_VH
`define LCW_SLAVE_ADDR 7'h3e
`define LCW_CTL_CONT_BIT 7
`define LCW_CTL_RSEL_BIT 6
`define LCW_DISPLAY_DATA_RAM_DEPTH 80
`define LCW_DISPLAY_DATA_RAM_LAST 7'h4f
`define LCW_GLYPH_DEPTH 64
`define LCW_ICON_DEPTH 16
`define LCW_BUSY_NS 400
`define LCW_CLK_NS 10
`define LCW_BUSY_CYC ((`LCW_BUSY_NS + `LCW_CLK_NS - 1) / `LCW_CLK_NS)
`define LCW_SEL_DISPLAY_DATA_RAM 2'h0
`define LCW_SEL_GLYPH 2'h1
`define LCW_SEL_ICON 2'h2
`endif

// ==== rtl/lcw_bus_cond.v ====
// detects start and stop conditions and clock edges on the two-wire bus
// assumes pin levels are synchronous to clk_in
`timescale 1ns/1ps
module lcw_bus_cond
(
	input wire clk_in,
	input wire rst_in,
	input wire scl_in,
	input wire sda_in,
	output reg start_out,
	output reg stop_out,
	output reg scl_rise_out,
	output reg scl_fall_out
);
reg scl_d_ff;
reg sda_d_ff;
// previous levels, idle high
always @(posedge clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		scl_d_ff <= 1'b1;
		sda_d_ff <= 1'b1;
		start_out <= 1'b0;
		stop_out <= 1'b0;
		scl_rise_out <= 1'b0;
		scl_fall_out <= 1'b0;
	end
	else
	begin
		scl_d_ff <= scl_in;
		sda_d_ff <= sda_in;
		start_out <= scl_d_ff & scl_in & sda_d_ff & ~sda_in;
		stop_out <= scl_d_ff & scl_in & ~sda_d_ff & sda_in;
		scl_rise_out <= ~scl_d_ff & scl_in;
		scl_fall_out <= scl_d_ff & ~scl_in;
	end
end
endmodule // lcw_bus_cond

// ==== rtl/lcw_display_data_ram_view.v ====
// one-line window start tracking for display data ram shifting
// assumes shift pulses come from decoded instructions or from ram writes with entry shift set
`timescale 1ns/1ps
`include "lcw_defs.vh"
module lcw_display_data_ram_view
(
	input wire clk_in,
	input wire rst_in,
	input wire home_in,
	input wire shift_in,
	input wire right_in,
	output reg [6:0] first_addr_out
);
// first shown address wraps within 00..4f
always @(posedge clk_in or posedge rst_in)
begin
	if (rst_in)
		first_addr_out <= 7'h00;
	else if (home_in)
		first_addr_out <= 7'h00;
	else if (shift_in)
	begin
		if (right_in)
			first_addr_out <= (first_addr_out == 7'h00) ? `LCW_DISPLAY_DATA_RAM_LAST : first_addr_out - 7'h01;
		else
			first_addr_out <= (first_addr_out == `LCW_DISPLAY_DATA_RAM_LAST) ? 7'h00 : first_addr_out + 7'h01;
	end
end
endmodule // lcw_display_data_ram_view

// ==== rtl/lcw_slave.v ====
// write-only two-wire slave front end of a character display controller
// assumes scl and sda levels synchronous to clk_in; bus master drives the clock
// Summary of operation
// - data only changes while clock low; change during clock high is a condition
// - data rising while clock high is a stop, returns to idle
// - each byte is eight bits msb first then one acknowledge slot
// - addressed device pulls data low through the acknowledge clock high
// - only slave address 0111110 answers, not configurable
// - unmatched address ignores the rest of the transfer, no acknowledge
// - command words are a control byte then one payload byte
// - after continuation flag zero, every byte until stop is payload
// - select one stores payload in the selected ram (display or glyph; no instruction selects icon) and advances pointer
// - select zero decodes payload as instruction and updates settings
// - control and payload bytes are acknowledged too while addressed
// - payload held in data holding register then moved to selected ram
// - instruction holding register is write only, never read back
// - busy indicator high during internal operation, instructions then refused
// - address pointer loaded by instruction, steps by one after each write
// - display ram holds 80 eight-bit codes with 7-bit pointer
// - one-line mode maps positions 1..80 to addresses 00..4f
// - left shift moves first address up, right wraps to 4f
// - device only ever drives the acknowledge bit back
`timescale 1ns/1ps
`include "lcw_defs.vh"
module lcw_slave
#(
	parameter BUSY_CYCLES = `LCW_BUSY_CYC
)
(
	input wire clk_in,
	input wire rst_in,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_out,
	output reg busy_out,
	output reg [6:0] addr_ptr_out,
	output reg entry_inc_out,
	output reg [1:0] ram_sel_out,
	output reg [6:0] first_addr_out,
	output reg display_on_out,
	output reg addressed_out
);
// ************************************************
// bus conditions
// ************************************************
// one-cycle condition and clock edge strobes from the pin watcher
wire start_w;
wire stop_w;
wire rise_w;
wire fall_w;
lcw_bus_cond u_cond
(
	.clk_in(clk_in),
	.rst_in(rst_in),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.start_out(start_w),
	.stop_out(stop_w),
	.scl_rise_out(rise_w),
	.scl_fall_out(fall_w)
);
// ************************************************
// receive state machine
// ************************************************
localparam ST_IDLE = 4'b0001;
localparam ST_BITS = 4'b0010;
localparam ST_ACK = 4'b0100;
localparam ST_IGN = 4'b1000;
localparam PH_ADDR = 2'h0;
localparam PH_CTRL = 2'h1;
localparam PH_DATA = 2'h2;
// receiver state, byte assembly and command word tracking
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [1:0] phase_ff;
reg [2:0] bit_cnt_ff;
reg [7:0] shift_ff;
reg [7:0] nxt_shift;
reg last_ctrl_ff;
reg rsel_ff;
reg byte_done;
reg ack_drive_ff;
// byte completes on the eighth rising clock edge
always @*
begin
	nxt_state = state_ff;
	nxt_shift = shift_ff;
	byte_done = 1'b0;
	case (state_ff)
		ST_IDLE:
			nxt_state = ST_IDLE;
		ST_BITS:
			if (rise_w)
			begin
				nxt_shift = {shift_ff[6:0], sda_in};
				if (bit_cnt_ff == 3'h7)
					byte_done = 1'b1;
			end
		ST_ACK:
			if (fall_w && ack_drive_ff)
				nxt_state = ST_BITS;
		ST_IGN:
			nxt_state = ST_IGN;
		default:
			nxt_state = ST_IDLE;
	endcase
end
// holding registers and their one-cycle hand-over strobes
reg instr_stb_ff;
reg data_stb_ff;
reg [7:0] instr_hold_ff;
reg [7:0] data_hold_ff;
// framing, phase tracking and acknowledge drive
always @(posedge clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		state_ff <= ST_IDLE;
		phase_ff <= PH_ADDR;
		bit_cnt_ff <= 3'h0;
		shift_ff <= 8'h00;
		last_ctrl_ff <= 1'b0;
		rsel_ff <= 1'b0;
		ack_drive_ff <= 1'b0;
		sda_out <= 1'b0;
		sda_oe_out <= 1'b0;
		addressed_out <= 1'b0;
		instr_stb_ff <= 1'b0;
		data_stb_ff <= 1'b0;
		instr_hold_ff <= 8'h00;
		data_hold_ff <= 8'h00;
	end
	else
	begin
		instr_stb_ff <= 1'b0;
		data_stb_ff <= 1'b0;
		sda_out <= 1'b0; // only ever pulls low
		shift_ff <= nxt_shift;
		if (stop_w)
		begin
			state_ff <= ST_IDLE;
			sda_oe_out <= 1'b0;
			ack_drive_ff <= 1'b0;
			addressed_out <= 1'b0;
		end
		else if (start_w)
		begin
			state_ff <= ST_BITS;
			phase_ff <= PH_ADDR;
			bit_cnt_ff <= 3'h0;
			last_ctrl_ff <= 1'b0;
			sda_oe_out <= 1'b0;
			ack_drive_ff <= 1'b0;
			addressed_out <= 1'b0;
		end
		else if (state_ff == ST_BITS && rise_w)
		begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (byte_done)
			begin
				state_ff <= ST_ACK;
				case (phase_ff)
					PH_ADDR:
						if (nxt_shift[7:1] == `LCW_SLAVE_ADDR && !nxt_shift[0])
						begin
							addressed_out <= 1'b1;
							phase_ff <= PH_CTRL;
						end
						else
							state_ff <= ST_IGN;
					PH_CTRL:
					begin
						rsel_ff <= nxt_shift[`LCW_CTL_RSEL_BIT];
						last_ctrl_ff <= ~nxt_shift[`LCW_CTL_CONT_BIT];
						phase_ff <= PH_DATA;
					end
					PH_DATA:
					begin
						phase_ff <= last_ctrl_ff ? PH_DATA : PH_CTRL;
						if (rsel_ff)
						begin
							data_hold_ff <= nxt_shift;
							data_stb_ff <= 1'b1;
						end
						else if (!busy_out)
						begin
							instr_hold_ff <= nxt_shift;
							instr_stb_ff <= 1'b1;
						end
					end
					default:
						phase_ff <= PH_ADDR;
				endcase
			end
		end
		else if (state_ff == ST_ACK && fall_w)
		begin
			// drive low from the clock fall after bit 8 until the fall after the ack pulse
			if (!ack_drive_ff)
			begin
				ack_drive_ff <= 1'b1;
				sda_oe_out <= 1'b1;
			end
			else
			begin
				ack_drive_ff <= 1'b0;
				sda_oe_out <= 1'b0;
				state_ff <= nxt_state;
			end
		end
	end
end
// ************************************************
// instruction decode, pointer and ram
// ************************************************
// target rams: display codes, user glyph rows and icon bits
reg [7:0] display_data_ram_mem [0:`LCW_DISPLAY_DATA_RAM_DEPTH-1];
reg [7:0] glyph_mem [0:`LCW_GLYPH_DEPTH-1];
reg [7:0] icon_mem [0:`LCW_ICON_DEPTH-1];
reg [15:0] busy_cnt_ff;
reg home_stb_ff;
reg shift_stb_ff;
reg shift_right_ff;
reg shift_disp_ff;
wire [6:0] first_w;
// step the pointer by one in the entry direction, wrapping display ram
function [6:0] step_ptr;
	input [6:0] ptr;
	input inc;
	input [1:0] sel;
	begin
		if (sel == `LCW_SEL_DISPLAY_DATA_RAM && inc)
			step_ptr = (ptr == `LCW_DISPLAY_DATA_RAM_LAST) ? 7'h00 : ptr + 7'h01;
		else if (sel == `LCW_SEL_DISPLAY_DATA_RAM)
			step_ptr = (ptr == 7'h00) ? `LCW_DISPLAY_DATA_RAM_LAST : ptr - 7'h01;
		else if (inc)
			step_ptr = ptr + 7'h01;
		else
			step_ptr = ptr - 7'h01;
	end
endfunction
// settings update and ram writes
always @(posedge clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		addr_ptr_out <= 7'h00;
		entry_inc_out <= 1'b1;
		ram_sel_out <= `LCW_SEL_DISPLAY_DATA_RAM;
		display_on_out <= 1'b0;
		busy_out <= 1'b0;
		busy_cnt_ff <= 16'h0000;
		home_stb_ff <= 1'b0;
		shift_stb_ff <= 1'b0;
		shift_right_ff <= 1'b0;
		shift_disp_ff <= 1'b0;
		first_addr_out <= 7'h00;
	end
	else
	begin
		home_stb_ff <= 1'b0;
		shift_stb_ff <= 1'b0;
		first_addr_out <= first_w;
		if (busy_cnt_ff != 16'h0000)
			busy_cnt_ff <= busy_cnt_ff - 16'h0001;
		else
			busy_out <= 1'b0;
		if (data_stb_ff)
		begin
			case (ram_sel_out)
				`LCW_SEL_DISPLAY_DATA_RAM:
					if (addr_ptr_out <= `LCW_DISPLAY_DATA_RAM_LAST)
						display_data_ram_mem[addr_ptr_out] <= data_hold_ff;
				`LCW_SEL_GLYPH:
					glyph_mem[addr_ptr_out[5:0]] <= data_hold_ff;
				default:
					icon_mem[addr_ptr_out[3:0]] <= data_hold_ff;
			endcase
			addr_ptr_out <= step_ptr(addr_ptr_out, entry_inc_out, ram_sel_out);
			if (shift_disp_ff)
			begin
				shift_stb_ff <= 1'b1;
				shift_right_ff <= ~entry_inc_out;
			end
		end
		else if (instr_stb_ff)
		begin
			// a new instruction restarts the count, so the set wins over expiry
			busy_out <= 1'b1;
			busy_cnt_ff <= BUSY_CYCLES[15:0];
			if (instr_hold_ff[7])
			begin
				addr_ptr_out <= instr_hold_ff[6:0];
				ram_sel_out <= `LCW_SEL_DISPLAY_DATA_RAM;
			end
			else if (instr_hold_ff[6])
			begin
				addr_ptr_out <= {1'b0, instr_hold_ff[5:0]};
				ram_sel_out <= `LCW_SEL_GLYPH;
			end
			else if (instr_hold_ff[4])
			begin
				shift_stb_ff <= instr_hold_ff[3];
				shift_right_ff <= instr_hold_ff[2];
			end
			else if (instr_hold_ff[3])
				display_on_out <= instr_hold_ff[2];
			else if (instr_hold_ff[2])
			begin
				entry_inc_out <= instr_hold_ff[1];
				shift_disp_ff <= instr_hold_ff[0];
			end
			else if (instr_hold_ff[1])
			begin
				addr_ptr_out <= 7'h00;
				home_stb_ff <= 1'b1;
			end
			else if (instr_hold_ff[0])
			begin
				addr_ptr_out <= 7'h00;
				entry_inc_out <= 1'b1;
				home_stb_ff <= 1'b1;
			end
		end
	end
end
// window start tracking for one-line display shifts
lcw_display_data_ram_view u_view
(
	.clk_in(clk_in),
	.rst_in(rst_in),
	.home_in(home_stb_ff),
	.shift_in(shift_stb_ff),
	.right_in(shift_right_ff),
	.first_addr_out(first_w)
);
endmodule // lcw_slave

// ==== bench/lcw_master.sv ====
// two-wire bus master model driving the serial clock and data
// assumes a pull-up on data; slave pulls low only
`timescale 1ns/1ps
module lcw_master
(
	input wire clk_in,
	input wire sda_in,
	output reg scl_out,
	output reg sda_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// waits n edges then steps past them
	task tick(input integer n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// data falls while clock high
	task start;
		tick(4);
		sda_out = 1'b0;
		tick(4);
		scl_out = 1'b0;
		tick(1);
	endtask
	// data rises while clock high, ends transfer
	task stop;
		sda_out = 1'b0;
		tick(4);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b1;
		tick(4);
	endtask
	// msb first, data moves only while clock low, then ack slot
	task put_byte(input [7:0] b, output ack);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
		begin
			sda_out = b[i];
			tick(4);
			scl_out = 1'b1;
			tick(4);
			scl_out = 1'b0;
			tick(1);
		end
		sda_out = 1'b1;
		tick(4);
		scl_out = 1'b1;
		tick(2);
		ack = ~sda_in;
		tick(2);
		scl_out = 1'b0;
		tick(1);
	endtask
endmodule // lcw_master

// ==== bench/lcw_slave_checker.sv ====
// concurrent checks on the slave's ports
// assumes binding to lcw_slave
`timescale 1ns/1ps
module lcw_slave_checker
#(
	parameter BUSY_CYCLES = 40
)
(
	input wire clk_in,
	input wire rst_in,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_out,
	input wire busy_out,
	input wire [6:0] addr_ptr_out,
	input wire entry_inc_out,
	input wire [1:0] ram_sel_out,
	input wire [6:0] first_addr_out,
	input wire display_on_out,
	input wire addressed_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sda_zero_a: assert property (sda_out == 1'b0) else $error("data driven high");
	ack_scope_a: assert property (sda_oe_out |-> addressed_out) else $error("ack when not addressed");
	ack_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
		else $error("ack moved in clock high");
	ack_release_a: assert property ($rose(sda_oe_out) |-> ##[1:100] !sda_oe_out) else $error("ack held");
	busy_bound_a: assert property ($rose(busy_out) |-> ##[1:300] !busy_out) else $error("busy stuck");
	ptr_range_a: assert property (ram_sel_out == 2'h0 |-> addr_ptr_out <= 7'h4f)
		else $error("pointer out of range");
	view_range_a: assert property (first_addr_out <= 7'h4f) else $error("view out of range");
	stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:4] !addressed_out)
		else $error("stop ignored");
endmodule // lcw_slave_checker
bind lcw_slave lcw_slave_checker #(.BUSY_CYCLES(BUSY_CYCLES)) chk (.clk_in(clk_in), .rst_in(rst_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
	.addr_ptr_out(addr_ptr_out), .entry_inc_out(entry_inc_out), .ram_sel_out(ram_sel_out),
	.first_addr_out(first_addr_out), .display_on_out(display_on_out), .addressed_out(addressed_out));

// ==== bench/tb_lcw_slave.sv ====
// self-checking bench for the write-only display slave
// assumes master model lcw_master and a pull-up on data
`timescale 1ns/1ps
module tb_lcw_slave;
	reg clk_in = 1'b0;
	reg rst_in = 1'b1;
	wire scl, m_sda, sda_out, sda_oe, busy, inc_o, disp_on, addressed;
	wire [6:0] ptr, first;
	wire [1:0] sel;
	wire sda_line = m_sda & ~(sda_oe & ~sda_out);
	integer bad_count = 0, compares = 0, k, n, j;
	reg [31:0] seed = 32'h8c83;
	reg [6:0] a, e;
	reg ack, inc;
	lcw_master m (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_out(m_sda));
	lcw_slave #(.BUSY_CYCLES(2)) dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_out(sda_oe), .busy_out(busy), .addr_ptr_out(ptr), .entry_inc_out(inc_o),
		.ram_sel_out(sel), .first_addr_out(first), .display_on_out(disp_on), .addressed_out(addressed));
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one pointer step with wrap inside display ram
	function [6:0] step(input [6:0] p, input up);
		step = up ? ((p == 7'h4f) ? 7'h00 : p + 7'h01) : ((p == 7'h00) ? 7'h4f : p - 7'h01);
	endfunction
	task check(input [7:0] seen, input [7:0] exp);
		compares = compares + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task send(input [7:0] b);
		m.put_byte(b, ack);
	endtask
	// cuts a hang short
	initial
	begin
		repeat (90000) @(posedge clk_in);
		bad_count = bad_count + 1;
		test_done;
	end
	initial
	begin
		repeat (10) @(posedge clk_in);
		#1 rst_in = 1'b0;
		check(inc_o, 1'b1);
		check(busy, 1'b0);
		seed = lfsr(seed);
		m.start;
		send({(seed[6:0] == 7'h3e) ? 7'h3f : seed[6:0], 1'b0}); check(ack, 1'b0);
		send(8'h80); check(ack, 1'b0);
		m.stop;
		m.start;
		send(8'h7d); check(ack, 1'b0);
		m.stop;
		m.start;
		send(8'h7c); check(ack, 1'b1);
		check(addressed, 1'b1);
		send(8'h80); check(ack, 1'b1);
		send(8'h0c); check(disp_on, 1'b1);
		send(8'h80);
		send(8'h18); check(first, 7'h01);
		send(8'h00);
		send(8'h1c); check(first, 7'h00);
		send(8'h1c); check(first, 7'h4f);
		send(8'hc5); check(ptr, 7'h45);
		send(8'h4a); check(sel, 2'h1);
		m.stop;
		check(addressed, 1'b0);
		for (k = 0; k < 4; k = k + 1)
		begin
			seed = lfsr(seed);
			a = (k == 0) ? 7'h4f : (k == 1) ? 7'h00 : seed[6:0] % 80;
			inc = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : seed[8];
			n = 1 + seed[11:9];
			m.start;
			send(8'h7c);
			send(8'h80);
			send({6'h01, inc, 1'b0}); check(inc_o, inc);
			send(8'h80);
			send({1'b1, a}); check(ptr, a);
			send(8'h40);
			e = a;
			for (j = 0; j < n; j = j + 1)
			begin
				seed = lfsr(seed);
				send(seed[7:0]); check(ack, 1'b1);
				e = step(e, inc);
			end
			check(ptr, e);
			check(sel, 2'h0);
			check(busy, 1'b0);
			m.stop;
		end
		test_done;
	end
endmodule // tb_lcw_slave
